// ### core/bmux_pkg.sv
package bmux_pkg;
  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned INT_SAMPLE_HZ   = 10_000;
  localparam int unsigned INT_DIV_CYC     = CLK_HZ / INT_SAMPLE_HZ;
  // External clock qualification window, in microseconds
  localparam int unsigned EXT_WIN_US      = 2_000;
  localparam int unsigned EXT_WIN_CYC     = (CLK_HZ / 1_000_000) * EXT_WIN_US;
  localparam int unsigned EXT_QUAL_EDGES  = 4;
  // ==========================================================
  // Button encoding
  typedef enum logic [1:0] {BTN_A, BTN_B, BTN_C, BTN_D} button_t;
  // ==========================================================
  // Synthesizer word
  localparam int unsigned SYN_BITS        = 17;
  localparam int unsigned KEY_BITS        = 16;
endpackage : bmux_pkg

// ### core/synth_if.sv
`timescale 1ns/1ps
interface synth_if;
  logic start;
  logic busy;
  logic [bmux_pkg::KEY_BITS-1:0] key;
  modport ctrl (output start, output key, input busy);
  modport ser  (input start, input key, output busy);
endinterface : synth_if

// ### core/synth_loader.sv
`timescale 1ns/1ps
module synth_loader
  import bmux_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic clkEn,
  synth_if.ser      sif,
  // Serial synthesizer pins
  output logic      synData,
  output logic      synClk,
  output logic      synLoad
);
  logic [SYN_BITS-1:0] shift_q;
  logic [4:0]          cnt_q;
  logic                phase_q;

  // ==========================================================
  // Word builder and shifter; first key bit sent twice
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_q <= '0;
      cnt_q   <= '0;
      phase_q <= 1'b0;
      synClk  <= 1'b0;
      synData <= 1'b0;
      synLoad <= 1'b0;
    end else if (clkEn) begin
      synLoad <= 1'b0;
      if (cnt_q == 5'h00) begin
        synClk <= 1'b0;
        if (sif.start) begin
          shift_q <= {sif.key[KEY_BITS-1], sif.key};
          cnt_q   <= 5'(SYN_BITS);
          phase_q <= 1'b0;
        end
      end else if (!phase_q) begin
        synData <= shift_q[SYN_BITS-1];
        synClk  <= 1'b0;
        phase_q <= 1'b1;
      end else begin
        synClk  <= 1'b1;
        shift_q <= {shift_q[SYN_BITS-2:0], 1'b0};
        cnt_q   <= cnt_q - 5'h01;
        phase_q <= 1'b0;
        synLoad <= (cnt_q == 5'h01);
      end
    end
  end

  assign sif.busy = (cnt_q != 5'h00);

  syn_len_a: assert property (@(posedge clk) disable iff (!arst_n)
    (clkEn && !sif.busy && sif.start) |=> sif.busy[*8])
    else $error("synth load ended too early");
endmodule : synth_loader

// ### core/button_mux_sequencer.sv
`timescale 1ns/1ps
// How it works
// - No controls applied: closed orbit, internal clock, gain loop on.
// - Common inputs act on all modules; per-module outputs are own.
// - Single sample select is active low; high keeps mode off.
// - Button select lines decode only in single mode, fixed mapping.
// - Undriven (high) select lines choose button C.
// - Gain loop off input low disables automatic gain.
// - External clock takes over after qualification; else internal.
// - Frame marker rises at start of button A sequence.
// - Frame marker high during A, low during B, C, D.
// - Frame marker runs at a quarter of sample rate.
// - With window fitted, switch conducts only in fast window; window at least 20 ns.
// - Lock good is high when locked and level adequate.
// - Synthesizer is loaded with a 17-bit serial word.
// - First key bit is sent as bit 17 and bit 16.
// - Single mode forces automatic gain off.
// - With window fitted, window low opens all switches; high closes the addressed one in single mode, else the sequenced one.
module button_mux_sequencer
  import bmux_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                clkEn,
  // Common external controls (shared across the chassis)
  input  wire logic                single_sample_sel_n,
  input  wire logic                button_sel0_n,
  input  wire logic                button_sel1_n,
  input  wire logic                peak_hold_clear_n,
  input  wire logic                gain_loop_off_n,
  input  wire logic                extClk,
  input  wire logic                fastWindow,
  input  wire logic                windowFitted,
  input  wire logic                singleFitted,
  // Per-module analog side status
  input  wire logic                demodLocked,
  input  wire logic                levelOk,
  input  wire logic [7:0]          peakSample,
  input  wire logic [7:0]          extGain,
  input  wire logic [7:0]          loopGainIn,
  input  wire logic [7:0]          horizIn,
  // Synthesizer key and trigger
  input  wire logic [KEY_BITS-1:0] freqKey,
  input  wire logic                synthStart,
  // Per-module outputs
  output logic [3:0]               muxSwitch,
  output logic                     frameMark,
  output logic                     lock_good,
  output logic                     gainLoopOn,
  output logic [7:0]               loop_gain_voltage,
  output logic [7:0]               horiz_out,
  output logic                     extSelected,
  output logic                     synData,
  output logic                     synClk,
  output logic                     synLoad,
  output logic                     synBusy
);
  // ==========================================================
  // Decoding
  function automatic button_t decodeSel(input logic s1n, input logic s0n);
    unique case ({s1n, s0n})
      2'b10:   decodeSel = BTN_A;
      2'b00:   decodeSel = BTN_B;
      2'b11:   decodeSel = BTN_C;
      2'b01:   decodeSel = BTN_D;
    endcase
  endfunction : decodeSel

  logic      singleMode;
  button_t   addrBtn;
  logic      extPrev_q;
  logic      extRise;
  logic [15:0] divCnt_q;
  logic      intTick;
  logic      tick;
  button_t   seq_q;
  logic [15:0] winCnt_q;
  logic [2:0]  edgeCnt_q;
  logic [7:0]  peak_q;

  // Single mode is active-low; sel lines ignored otherwise
  assign singleMode = !single_sample_sel_n;
  // Pull-ups make floating lines read high, i.e. button C
  assign addrBtn = decodeSel(button_sel1_n, button_sel0_n);
  assign extRise = extClk && !extPrev_q;

  // ==========================================================
  // Internal sample clock divider
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divCnt_q <= '0;
    end else if (clkEn) begin
      if (divCnt_q == 16'(INT_DIV_CYC - 1)) begin
        divCnt_q <= '0;
      end else begin
        divCnt_q <= divCnt_q + 16'h0001;
      end
    end
  end
  assign intTick = (divCnt_q == 16'(INT_DIV_CYC - 1));

  // ==========================================================
  // External clock qualification: enough edges before window expires
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      extPrev_q   <= 1'b0;
      winCnt_q    <= '0;
      edgeCnt_q   <= '0;
      extSelected <= 1'b0;
    end else if (clkEn) begin
      extPrev_q <= extClk;
      if (extRise) begin
        winCnt_q <= '0;
        if (edgeCnt_q == 3'(EXT_QUAL_EDGES)) begin
          extSelected <= 1'b1;
        end else begin
          edgeCnt_q <= edgeCnt_q + 3'h1;
        end
      end else if (winCnt_q == 16'(EXT_WIN_CYC - 1)) begin
        // Clock lost: fall back to the internal source
        edgeCnt_q   <= '0;
        extSelected <= 1'b0;
      end else begin
        winCnt_q <= winCnt_q + 16'h0001;
      end
    end
  end

  assign tick = extSelected ? extRise : intTick;

  // ==========================================================
  // Button sequencer, wraps D to A
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_q <= BTN_A;
    end else if (clkEn && tick) begin
      seq_q <= button_t'(seq_q + 2'h1);
    end
  end

  // ==========================================================
  // Frame marker: high during A, a quarter of the sample rate
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frameMark <= 1'b0;
    end else if (clkEn) begin
      frameMark <= (seq_q == BTN_A);
    end
  end

  // ==========================================================
  // Multiplexer switches, gated by the fast window when fitted
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      muxSwitch <= 4'h0;
    end else if (clkEn) begin
      if (windowFitted && !fastWindow) begin
        muxSwitch <= 4'h0;
      end else if (singleMode || windowFitted) begin
        // Addressed button only; in closed orbit use sequencer
        muxSwitch <= 4'h1 << (singleMode ? addrBtn : seq_q);
      end else begin
        muxSwitch <= 4'h1 << seq_q;
      end
    end
  end

  // ==========================================================
  // Gain loop control and gain voltage source
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gainLoopOn        <= 1'b1;
      loop_gain_voltage <= 8'h00;
    end else if (clkEn) begin
      gainLoopOn <= gain_loop_off_n && !singleMode;
      if (!gain_loop_off_n) begin
        loop_gain_voltage <= extGain;
      end else begin
        loop_gain_voltage <= loopGainIn;
      end
    end
  end

  // ==========================================================
  // Peak hold and horizontal output select
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      peak_q    <= 8'h00;
      horiz_out <= 8'h00;
    end else if (clkEn) begin
      if (!peak_hold_clear_n) begin
        peak_q <= 8'h00;
      end else if (peakSample > peak_q) begin
        peak_q <= peakSample;
      end
      horiz_out <= (singleFitted && singleMode) ? peak_q : horizIn;
    end
  end

  // ==========================================================
  // Lock status, per module
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_good <= 1'b0;
    end else if (clkEn) begin
      lock_good <= demodLocked && levelOk;
    end
  end

  // ==========================================================
  // Synthesizer loader
  synth_if sif ();
  assign sif.start = synthStart;
  assign sif.key   = freqKey;

  synth_loader u_loader (
    .clk     (clk),
    .arst_n  (arst_n),
    .clkEn   (clkEn),
    .sif     (sif),
    .synData (synData),
    .synClk  (synClk),
    .synLoad (synLoad)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      synBusy <= 1'b0;
    end else if (clkEn) begin
      synBusy <= sif.busy;
    end
  end

  // ==========================================================
  // Checks
  sequence seqStepAD;
    clkEn && tick && seq_q == BTN_D;
  endsequence
  seq_wrap_a: assert property (@(posedge clk) disable iff (!arst_n)
    seqStepAD |=> seq_q == BTN_A)
    else $error("sequencer did not wrap to A");
  frame_mark_a: assert property (@(posedge clk) disable iff (!arst_n)
    clkEn |=> frameMark == ($past(seq_q) == BTN_A))
    else $error("frame marker mismatch");
  window_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    (clkEn && windowFitted && !fastWindow) |=> muxSwitch == 4'h0)
    else $error("switch closed outside window");
  single_gain_a: assert property (@(posedge clk) disable iff (!arst_n)
    (clkEn && singleMode) |=> !gainLoopOn)
    else $error("gain loop left on in single mode");
  gain_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    (clkEn && !gain_loop_off_n) |=> !gainLoopOn)
    else $error("gain loop not disabled");
  lock_good_a: assert property (@(posedge clk) disable iff (!arst_n)
    clkEn |=> lock_good == ($past(demodLocked) && $past(levelOk)))
    else $error("lock status wrong");
  peak_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    (clkEn && !peak_hold_clear_n) |=> peak_q == 8'h00)
    else $error("peak not cleared");
  single_addr_a: assert property (@(posedge clk) disable iff (!arst_n)
    (clkEn && singleMode && !windowFitted && button_sel1_n && button_sel0_n)
      |=> muxSwitch == 4'h4)
    else $error("default button is not C");
endmodule : button_mux_sequencer

// ### verif/ctrl_partner.sv
`timescale 1ns/1ps
// ==========================================================
// Controller model: external sample clock source
module ctrl_partner (
  // Clock and control
  input  wire logic        clk,
  input  wire logic        extRun,
  input  wire logic [15:0] periodCyc,
  // External clock pin
  output logic             extClk
);
  int cnt;
  // Half high, half low; periods from 625 cycles keep the rate legal
  always @(posedge clk) begin
    if (!extRun) begin
      cnt    <= 0;
      extClk <= 1'b0; // Idle low between bursts
    end else begin
      cnt    <= (cnt + 1 >= periodCyc) ? 0 : cnt + 1;
      extClk <= (cnt < periodCyc / 2);
    end
  end
endmodule : ctrl_partner

// ### verif/test_button_mux_sequencer.sv
`timescale 1ns/1ps
module test_button_mux_sequencer
  import bmux_pkg::*;
;
  // ========================================================
  // Signals
  logic clk = 1'b0, arst_n = 1'b0, clkEn = 1'b1, extRun = 1'b0;
  logic single_sample_sel_n = 1'b1, button_sel0_n = 1'b1;
  logic button_sel1_n = 1'b1, peak_hold_clear_n = 1'b1, extClk;
  logic gain_loop_off_n = 1'b1, fastWindow = 1'b1, windowFitted = 1'b0;
  logic singleFitted = 1'b0, demodLocked = 1'b0, levelOk = 1'b0;
  logic [7:0]  peakSample = 8'h00, extGain = 8'h00, loopGainIn = 8'h00;
  logic [7:0]  horizIn = 8'h00, loop_gain_voltage, horiz_out;
  logic [15:0] freqKey = 16'h0000, periodCyc = 16'h0400;
  logic        synthStart = 1'b0, frameMark, lock_good, gainLoopOn;
  logic [3:0]  muxSwitch;
  logic        extSelected, synData, synClk, synLoad, synBusy;
  int          errCount = 0, checksDone = 0, cycles = 0;

  always #20 clk = ~clk;

  // Ceiling well above the roughly 30k cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      errCount++;
      endSim();
    end
  end

  button_mux_sequencer i_button_mux_sequencer (
    .clk, .arst_n, .clkEn, .single_sample_sel_n, .button_sel0_n,
    .button_sel1_n, .peak_hold_clear_n, .gain_loop_off_n, .extClk,
    .fastWindow, .windowFitted, .singleFitted, .demodLocked, .levelOk,
    .peakSample, .extGain, .loopGainIn, .horizIn, .freqKey, .synthStart,
    .muxSwitch, .frameMark, .lock_good, .gainLoopOn, .loop_gain_voltage,
    .horiz_out, .extSelected, .synData, .synClk, .synLoad, .synBusy
  );
  ctrl_partner i_ctrl_partner (.clk, .extRun, .periodCyc, .extClk);

  // ========================================================
  // Helpers
  task automatic endSim();
    if (errCount == 0 && checksDone > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : endSim

  task automatic check(input string what, input logic [16:0] seen,
                       input logic [16:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Inputs always move 1 ns after the rising edge
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Active-low select pair to one-hot switch
  function automatic logic [3:0] btnHot(input logic [1:0] sel);
    case (sel)
      2'b10:   return 4'h1;
      2'b00:   return 4'h2;
      2'b11:   return 4'h4;
      default: return 4'h8;
    endcase
  endfunction : btnHot

  task automatic waitMark(input logic v);
    int n;
    n = 0;
    while (frameMark !== v && n < 20000) begin
      step();
      n++;
    end
  endtask : waitMark

  // Times one frame from a marker rise; logs switch changes
  task automatic frame(output int hi, output int per,
                       output logic [15:0] seq);
    waitMark(1'b0);
    waitMark(1'b1);
    hi  = 0;
    per = 0;
    seq = {12'h000, muxSwitch};
    do begin
      if (frameMark === 1'b1) hi++;
      step();
      per++;
      if (muxSwitch !== seq[3:0]) seq = {seq[11:0], muxSwitch};
    end while (!(frameMark === 1'b1 && hi < per) && per < 20000);
  endtask : frame

  // ========================================================
  // Main sequence
  initial begin
    int hi, per, bits, loads, n;
    logic [15:0] seq;
    logic [7:0]  pk;
    logic [16:0] word;
    logic        pc;
    void'($urandom(32'h39C33E8E));
    step(16);
    arst_n = 1'b1;
    step(2);
    check("gainLoopOn", gainLoopOn, 1'b1);
    check("extSelected", extSelected, 1'b0);
    frame(hi, per, seq);
    check("intHigh", hi, INT_DIV_CYC);
    check("intFrame", per, 4 * INT_DIV_CYC);
    check("intSeq", seq, 16'h2481);
    // Random controls; first four cover every button code
    for (int i = 0; i < 24; i++) begin
      {button_sel1_n, button_sel0_n} = (i < 4) ? i[1:0] : 2'($urandom);
      single_sample_sel_n = (i < 4) ? 1'b0 : 1'($urandom);
      {gain_loop_off_n, windowFitted, fastWindow} = 3'($urandom);
      {singleFitted, demodLocked, levelOk} = 3'($urandom);
      {extGain, loopGainIn, horizIn} = 24'($urandom);
      step(2);
      check("loopOn", gainLoopOn, gain_loop_off_n & single_sample_sel_n);
      check("gainV", loop_gain_voltage, gain_loop_off_n ? loopGainIn : extGain);
      check("lock", lock_good, demodLocked & levelOk);
      if (windowFitted && !fastWindow) begin
        check("muxShut", muxSwitch, 4'h0);
      end else if (!single_sample_sel_n) begin
        check("muxSel", muxSwitch, btnHot({button_sel1_n, button_sel0_n}));
      end
      if (!(singleFitted && !single_sample_sel_n)) begin
        check("horiz", horiz_out, horizIn);
      end
    end
    // Peak hold: clear, then capture the largest sample
    // Clock enable low freezes state; the toggle must not land
    single_sample_sel_n = 1'b1;
    step(2);
    clkEn = 1'b0;
    gain_loop_off_n = !gain_loop_off_n;
    step(3);
    check("frozen", gainLoopOn, !gain_loop_off_n);
    clkEn = 1'b1;
    step(2);
    check("thawed", gainLoopOn, gain_loop_off_n);
    // Peak hold: capture first so that a clear is visible
    {singleFitted, single_sample_sel_n, windowFitted} = 3'b100;
    peakSample = 8'hC3;
    step(3);
    check("peakCap", horiz_out, 8'hC3);
    peak_hold_clear_n = 1'b0;
    step(3);
    check("peakClr", horiz_out, 8'h00);
    peak_hold_clear_n = 1'b1;
    pk = 8'h00;
    repeat (4) begin
      peakSample = 8'($urandom);
      if (peakSample > pk) pk = peakSample;
      step();
    end
    peakSample = 8'h00;
    step(3);
    check("peakHold", horiz_out, pk);
    single_sample_sel_n = 1'b1;
    // Synthesizer word, shifted in on each serial clock rise
    freqKey = 16'($urandom);
    synthStart = 1'b1;
    step();
    synthStart = 1'b0;
    {word, bits, loads, n, pc} = '0;
    repeat (60) begin
      step();
      if (synBusy) n++;
      if (synClk && !pc) word = {word[15:0], synData};
      if (synClk && !pc) bits++;
      if (synLoad) loads++;
      pc = synClk;
    end
    check("synBits", bits, SYN_BITS);
    check("synWord", word, {freqKey[15], freqKey});
    check("synLoad", loads, 1);
    check("synBusy", n, 2 * SYN_BITS);
    // External clock: few edges refused, then takes over
    periodCyc = 16'(625 + $urandom_range(375));
    extRun = 1'b1;
    step(2 * periodCyc);
    check("extEarly", extSelected, 1'b0);
    n = 0;
    while (extSelected !== 1'b1 && n < 8 * periodCyc) begin
      step();
      n++;
    end
    check("extSel", extSelected, 1'b1);
    frame(hi, per, seq);
    check("extHigh", hi, periodCyc);
    check("extFrame", per, 4 * periodCyc);
    check("extSeq", seq, 16'h2481);
    endSim();
  end
endmodule : test_button_mux_sequencer
